// [shared/ddr_cmd_pkg.sv]
// Constants shared by the memory-die command, burst and buffer logic
package ddr_cmd_pkg;
	// Local clock
	localparam int CLK_PERIOD_NS = 20;
	// Precharge times, least times rounded up to whole clocks
	localparam int T_RPPB_NS = 18;
	localparam int T_RPAB_NS = 21;
	localparam logic [4:0] RPPB_CYC = 5'((T_RPPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] RPAB_CYC = 5'((T_RPAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Latencies and burst length after reset of the mode settings
	localparam int RL_DEF = 8;
	localparam int WL_DEF = 4;
	localparam int BL_DEF = 8;
	// Widths
	localparam int CA_W  = 10;
	localparam int COL_W = 11;
	// Field positions on the command/address bus
	localparam int CA_RDWR_BIT = 2;
	localparam int CA_AB_BIT   = 4;
	localparam int CA_COLR_LSB = 5;
	localparam int CA_COLF_LSB = 1;
	localparam int CA_BA_LSB   = 7;
	// Decoded commands
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_ACT  = 3'h1,
		CMD_RD   = 3'h2,
		CMD_WR   = 3'h3,
		CMD_BST  = 3'h4,
		CMD_PRE  = 3'h5
	} cmd_t;
endpackage

// [shared/word_if.sv]
// Valid/ready word channel between the core and its buffer
`timescale 1ns/1ps
interface word_if #(
	parameter int W = 19
) ();
	logic         valid; // Word offered
	logic         ready; // Word accepted
	logic [W-1:0] data;  // Payload
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// [src/word_buffer.sv]
// Small shift buffer with valid and ready on both sides
`timescale 1ns/1ps
module word_buffer #(
	parameter int W     = 19,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	word_if.snk               in_w,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic [DEPTH-1:0]        vld; // Entry holds a word, head at 0
		logic [DEPTH-1:0][W-1:0] mem; // Stored words
	} buf_t;
	buf_t s_reg;
	buf_t s_next;

	// Full only when the last slot holds a word
	assign in_w.ready = ~s_reg.vld[DEPTH-1];
	assign out_valid  = s_reg.vld[0];
	assign out_data   = s_reg.mem[0];

	// Pop shifts toward the head, push fills the first free slot
	always_comb begin
		logic placed;
		placed = 1'b0;
		s_next = s_reg;
		if (s_reg.vld[0] && out_ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_next.mem[i] = s_reg.mem[i+1];
				s_next.vld[i] = s_reg.vld[i+1];
			end
			s_next.vld[DEPTH-1] = 1'b0;
		end
		if (in_w.valid && ~s_reg.vld[DEPTH-1]) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!s_next.vld[i] && !placed) begin
					s_next.mem[i] = in_w.data;
					s_next.vld[i] = 1'b1;
					placed        = 1'b1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

// [src/ddr_die_core.sv]
// Command decode, bank tracking, read burst driver and write capture of the memory die
`timescale 1ns/1ps
module ddr_die_core #(
	parameter int RL   = ddr_cmd_pkg::RL_DEF, // Read latency in link clocks, at least 2
	parameter int WL   = ddr_cmd_pkg::WL_DEF, // Write latency in link clocks, at least 1
	parameter int BL   = ddr_cmd_pkg::BL_DEF, // Burst length 4, 8 or 16
	parameter int DQ_W = 8                    // Data byte lane width
) (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          ck,
	input  wire logic                          cs_n,
	input  wire logic [ddr_cmd_pkg::CA_W-1:0]  ca,
	input  wire logic [DQ_W-1:0]               dq_i,
	output logic      [DQ_W-1:0]               dq_o,
	output logic                               dq_oe,
	input  wire logic                          dqs_i,
	output logic                               dqs_o,
	output logic                               dqs_oe,
	output logic      [ddr_cmd_pkg::COL_W-1:0] rd_addr,
	input  wire logic [DQ_W-1:0]               rd_data,
	output logic                               wr_valid,
	input  wire logic                          wr_ready,
	output logic      [ddr_cmd_pkg::COL_W-1:0] wr_col,
	output logic      [DQ_W-1:0]               wr_data,
	output logic                               wr_overflow,
	output logic      [7:0]                    open_banks,
	output logic                               cmd_err
);
	localparam int COL_W = ddr_cmd_pkg::COL_W;
	localparam int PW    = COL_W + DQ_W;
	localparam logic [4:0] BL_LEN  = 5'(BL);
	localparam logic [4:0] AGE_LIM = 5'(BL / 2 - 1);

	typedef struct packed {
		logic                      ck_m, ck_s, ck_d;    // Link clock sync and delay
		logic                      cs_m, cs_s;          // Chip select sync
		logic [9:0]                ca_m, ca_s;          // Command bus sync
		logic                      dqs_m, dqs_s, dqs_d; // Strobe sync and delay
		logic [DQ_W-1:0]           dq_m, dq_s;          // Write data sync
		logic [1:0]                cpend;               // Column waits for falling half
		logic [RL:0]               rsr;                 // Read issued n link clocks ago
		logic [RL:0][4:0]          rlen;                // Effective read lengths
		logic [RL:0][COL_W-1:0]    rcol;                // Read start columns
		logic [WL:0]               wsr;                 // Write issued n link clocks ago
		logic [WL:0][4:0]          wlen;                // Effective write lengths
		logic [WL:0][COL_W-1:0]    wcol;                // Write start columns
		logic                      lastv, last_rd;      // Latest column command and kind
		logic [4:0]                age;                 // Link clocks since that command
		logic [4:0]                rbeats;              // Read beats still to send
		logic [COL_W-1:0]          raddr;               // Column of next read beat
		logic [DQ_W-1:0]           dq_o;                // Read data out
		logic                      dq_oe, dqs_o, dqs_oe;
		logic [4:0]                wbeats;              // Write beats still to take
		logic [5:0]                wtaken;              // Beats of latest write taken
		logic                      wseen;               // First strobe rise seen
		logic [COL_W-1:0]          wnext, wcur;         // Start and running columns
		logic                      pv;                  // Captured word offered
		logic [PW-1:0]             pd;                  // Captured column and data
		logic                      ovf;                 // Word refused by a full buffer
		logic [7:0]                bank_open;           // Activated banks
		logic [7:0]                pch_mask;            // Banks still precharging
		logic [4:0]                pch_cnt;             // Precharge time left
		logic                      err;                 // Illegal bank access seen
	} core_t;
	core_t s;
	core_t n;

	word_if #(.W(PW)) bin ();

	// Edges and command decode on the synchronised link
	logic                   ck_rise, ck_fall, dqs_r, dqs_f;
	logic [2:0]             ba;
	ddr_cmd_pkg::cmd_t      cmd;
	logic [5:0]             bidx;
	assign ck_rise = s.ck_s & ~s.ck_d;
	assign ck_fall = ~s.ck_s & s.ck_d;
	assign dqs_r   = s.dqs_s & ~s.dqs_d;
	assign dqs_f   = ~s.dqs_s & s.dqs_d;
	assign ba      = s.ca_s[ddr_cmd_pkg::CA_BA_LSB +: 3];
	assign bidx    = {1'b0, s.age} + 6'h01;
	always_comb begin
		cmd = ddr_cmd_pkg::CMD_NONE;
		if (ck_rise && !s.cs_s) begin
			if (s.ca_s[1:0] == 2'b10) begin
				cmd = ddr_cmd_pkg::CMD_ACT;
			end else if (s.ca_s[1:0] == 2'b01) begin
				cmd = s.ca_s[ddr_cmd_pkg::CA_RDWR_BIT] ? ddr_cmd_pkg::CMD_RD
					: ddr_cmd_pkg::CMD_WR;
			end else if (s.ca_s[3:0] == 4'b0011) begin
				cmd = ddr_cmd_pkg::CMD_BST;
			end else if (s.ca_s[3:0] == 4'b1011) begin
				cmd = ddr_cmd_pkg::CMD_PRE;
			end
		end
	end

	// Next state of the whole core
	always_comb begin
		logic [4:0] nlen;
		logic       trunc;
		logic [4:0] wprev;
		nlen  = {s.age[3:0], 1'b0} + 5'h02;
		trunc = 1'b0;
		wprev = 5'h00;
		n = s;
		// Two flip-flops on every pin before use
		n.ck_m  = ck;
		n.ck_s  = s.ck_m;
		n.ck_d  = s.ck_s;
		n.cs_m  = cs_n;
		n.cs_s  = s.cs_m;
		n.ca_m  = ca;
		n.ca_s  = s.ca_m;
		n.dqs_m = dqs_i;
		n.dqs_s = s.dqs_m;
		n.dqs_d = s.dqs_s;
		n.dq_m  = dq_i;
		n.dq_s  = s.dq_m;
		n.err   = 1'b0;
		n.pv    = 1'b0;
		n.ovf   = s.pv & ~bin.ready;
		if (s.pch_cnt != 5'h00) begin
			n.pch_cnt = s.pch_cnt - 5'h01;
		end
		// Read beats leave on both link edges, edge aligned with the strobe
		if (ck_rise || ck_fall) begin
			if (s.rbeats != 5'h00) begin
				n.dq_o   = rd_data;
				n.dqs_o  = ~s.dqs_o;
				n.rbeats = s.rbeats - 5'h01;
				n.raddr  = s.raddr + 11'h001;
			end else if (s.dq_oe) begin
				// Burst over and nothing chained: release the pins
				n.dq_oe  = 1'b0;
				n.dqs_oe = 1'b0;
				n.dqs_o  = 1'b0;
			end
		end
		// Write beats taken on every strobe edge after the first rise
		if (s.wbeats != 5'h00 && (dqs_r || (dqs_f && s.wseen))) begin
			n.pv     = 1'b1;
			n.pd     = {(s.wtaken == 6'h00) ? s.wnext : s.wcur, s.dq_s};
			n.wcur   = ((s.wtaken == 6'h00) ? s.wnext : s.wcur) + 11'h001;
			n.wbeats = s.wbeats - 5'h01;
			n.wtaken = s.wtaken + 6'h01;
			if (dqs_r) begin
				n.wseen = 1'b1;
			end
		end
		if (ck_fall) begin
			// Falling half completes the column address
			if (s.cpend[0]) begin
				n.rcol[0][COL_W-1:2] = s.ca_s[ddr_cmd_pkg::CA_COLF_LSB +: 9];
			end
			if (s.cpend[1]) begin
				n.wcol[0][COL_W-1:2] = s.ca_s[ddr_cmd_pkg::CA_COLF_LSB +: 9];
			end
			n.cpend = 2'b00;
			// Read starting next rise: present its column early
			if (s.rsr[RL-1]) begin
				n.raddr = n.rcol[RL-1];
			end
			// Write window opens half a link clock before its data
			if (s.wsr[WL-1]) begin
				wprev    = n.wbeats;
				n.wbeats = wprev + n.wlen[WL-1];
				n.wnext  = n.wcol[WL-1];
				n.wtaken = 6'h00 - {1'b0, wprev};
				if (wprev == 5'h00) begin
					n.wseen = 1'b0;
				end
			end
		end
		if (ck_rise) begin
			// Age every in-flight command by one link clock
			n.rsr  = {s.rsr[RL-1:0], cmd == ddr_cmd_pkg::CMD_RD};
			n.rlen = {s.rlen[RL-1:0], BL_LEN};
			n.rcol = {s.rcol[RL-1:0],
				{9'h000, s.ca_s[ddr_cmd_pkg::CA_COLR_LSB +: 2]}};
			n.wsr  = {s.wsr[WL-1:0], cmd == ddr_cmd_pkg::CMD_WR};
			n.wlen = {s.wlen[WL-1:0], BL_LEN};
			n.wcol = {s.wcol[WL-1:0],
				{9'h000, s.ca_s[ddr_cmd_pkg::CA_COLR_LSB +: 2]}};
			// Terminate or same-kind interrupt shortens only the latest burst
			trunc = s.lastv && s.age < AGE_LIM && (cmd == ddr_cmd_pkg::CMD_BST
				|| (cmd == ddr_cmd_pkg::CMD_RD && s.last_rd)
				|| (cmd == ddr_cmd_pkg::CMD_WR && !s.last_rd));
			if (trunc && s.last_rd && bidx <= 6'(RL)) begin
				if (nlen < n.rlen[bidx]) begin
					n.rlen[bidx] = nlen;
				end
			end else if (trunc && !s.last_rd && bidx < 6'(WL)) begin
				if (nlen < n.wlen[bidx]) begin
					n.wlen[bidx] = nlen;
				end
			end else if (trunc && !s.last_rd) begin
				// Write already capturing: stop after nlen beats of it
				if ($signed(n.wtaken) < $signed({1'b0, nlen})) begin
					n.wbeats = 5'({1'b0, nlen} - n.wtaken);
				end else begin
					n.wbeats = 5'h00;
				end
			end
			if (cmd == ddr_cmd_pkg::CMD_RD || cmd == ddr_cmd_pkg::CMD_WR) begin
				n.age     = 5'h00;
				n.lastv   = 1'b1;
				n.last_rd = (cmd == ddr_cmd_pkg::CMD_RD);
				n.cpend   = {cmd == ddr_cmd_pkg::CMD_WR, cmd == ddr_cmd_pkg::CMD_RD};
				if (!s.bank_open[ba]) begin
					n.err = 1'b1;
				end
			end else if (s.age != 5'h1f) begin
				n.age = s.age + 5'h01;
			end
			// Bank state
			if (cmd == ddr_cmd_pkg::CMD_ACT) begin
				if (s.bank_open[ba] || (s.pch_mask[ba] && s.pch_cnt != 5'h00)) begin
					n.err = 1'b1;
				end else begin
					n.bank_open[ba] = 1'b1;
				end
			end
			if (cmd == ddr_cmd_pkg::CMD_PRE) begin
				if (s.ca_s[ddr_cmd_pkg::CA_AB_BIT]) begin
					n.bank_open = 8'h00;
					n.pch_mask  = 8'hff;
					n.pch_cnt   = ddr_cmd_pkg::RPAB_CYC;
				end else begin
					n.bank_open[ba] = 1'b0;
					n.pch_mask      = 8'h01 << ba;
					n.pch_cnt       = ddr_cmd_pkg::RPPB_CYC;
				end
			end
			// Preamble: strobe driven low one link clock before data
			if (n.rsr[RL-1] && n.rbeats == 5'h00 && !n.dq_oe) begin
				n.dqs_oe = 1'b1;
				n.dqs_o  = 1'b0;
			end
			// First beat on the rise RL link clocks after the command
			if (n.rsr[RL]) begin
				n.dq_o   = rd_data;
				n.dq_oe  = 1'b1;
				n.dqs_oe = 1'b1;
				n.dqs_o  = 1'b1;
				n.rbeats = n.rlen[RL] - 5'h01;
				n.raddr  = s.raddr + 11'h001;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Captured words wait here, two deep; a word offered while both slots are full is lost and flags wr_overflow
	assign bin.valid = s.pv;
	assign bin.data  = s.pd;
	word_buffer #(.W(PW), .DEPTH(2)) u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.in_w      (bin),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_col, wr_data})
	);

	// Outputs straight from the state register
	assign dq_o        = s.dq_o;
	assign dq_oe       = s.dq_oe;
	assign dqs_o       = s.dqs_o;
	assign dqs_oe      = s.dqs_oe;
	assign rd_addr     = s.raddr;
	assign wr_overflow = s.ovf;
	assign open_banks  = s.bank_open;
	assign cmd_err     = s.err;

	// Checks
	sequence s_rd_cmd;
		cmd == ddr_cmd_pkg::CMD_RD;
	endsequence
	sequence s_start_due;
		ck_rise && s.rsr[RL-1];
	endsequence
	a_read_decode: assert property (@(posedge clk) disable iff (!nrst)
		s_rd_cmd |=> s.rsr[0] && !s.wsr[0]) else $error("read not queued");
	a_write_decode: assert property (@(posedge clk) disable iff (!nrst)
		cmd == ddr_cmd_pkg::CMD_WR |=> s.wsr[0] && !s.rsr[0])
		else $error("write not queued");
	a_activate_open: assert property (@(posedge clk) disable iff (!nrst)
		cmd == ddr_cmd_pkg::CMD_ACT && !s.bank_open[ba] && s.pch_cnt == 5'h00
		|=> open_banks[$past(ba)] && !cmd_err) else $error("bank not opened");
	a_bst_length: assert property (@(posedge clk) disable iff (!nrst)
		cmd == ddr_cmd_pkg::CMD_BST && s.lastv && s.last_rd && s.age < AGE_LIM
		|=> s.rlen[$past(bidx)] == 5'({$past(bidx), 1'b0}))
		else $error("terminated length wrong");
	a_read_preamble: assert property (@(posedge clk) disable iff (!nrst)
		$rose(dqs_oe) && !dq_oe |-> (!dqs_o && !dq_oe) [*6])
		else $error("preamble too short");
	a_first_beat: assert property (@(posedge clk) disable iff (!nrst)
		s_start_due |=> dqs_o && dq_oe && dqs_oe) else $error("first read beat late");
	a_column_addr: assert property (@(posedge clk) disable iff (!nrst)
		ck_fall && s.rsr[RL-1] |=> rd_addr == $past(n.rcol[RL-1]))
		else $error("burst column wrong");
	a_write_beat: assert property (@(posedge clk) disable iff (!nrst)
		s.wbeats != 5'h00 && dqs_r && !ck_rise && !ck_fall
		|=> s.pv && s.wbeats == $past(s.wbeats) - 5'h01)
		else $error("write beat missed");
	a_precharge_all: assert property (@(posedge clk) disable iff (!nrst)
		cmd == ddr_cmd_pkg::CMD_PRE && s.ca_s[ddr_cmd_pkg::CA_AB_BIT]
		|=> open_banks == 8'h00 && s.pch_cnt == ddr_cmd_pkg::RPAB_CYC)
		else $error("all-bank precharge timing wrong");
endmodule

// [tb/ctl_model.sv]
// Behavioural memory controller: link clock, commands and write bursts
`timescale 1ns/1ps
module ctl_model #(
	parameter int WL = 4 // Write latency in link clocks
) (
	output logic       ck,
	output logic       cs_n,
	output logic [9:0] ca,
	output logic [7:0] dq,
	output logic       dqs
);
	realtime t_cmd; // Rising edge of the latest command
	// Idle levels at time zero
	initial begin
		ck = 1'b0;
		cs_n = 1'b1;
		ca = 10'h000;
		dq = 8'h00;
		dqs = 1'b0;
	end
	// Free-running link clock, 160 ns
	always #80 ck = ~ck;
	// One command: rise half, fall half, then deselect
	task automatic cmd(input logic [9:0] r, input logic [9:0] f);
		@(negedge ck) #40;
		cs_n = 1'b0;
		ca = r;
		@(posedge ck) t_cmd = $realtime;
		#40;
		ca = f;
		@(negedge ck) #40;
		cs_n = 1'b1;
		ca = ~f; // Deselected bus does not keep its value
	endtask
	// Write data: strobe held low as preamble, one beat per strobe edge
	task automatic burst(input int n, input logic [7:0] base);
		#(WL * 160 - 160);
		for (int i = 0; i < n; i++) begin
			dq = base + 8'(i);
			#40;
			dqs = ~dqs;
			#40;
		end
		dq = ~dq; // Released data does not keep its value
	endtask
endmodule

// [tb/ddr_die_core_bench.sv]
// Self-checking bench for the memory-die command and burst core
`timescale 1ns/1ps
module ddr_die_core_bench;
	localparam int RL = 8; // Read latency in link clocks
	localparam int WL = 4; // Write latency in link clocks
	logic        clk = 1'b0;      // System clock
	logic        nrst = 1'b0;     // Reset, active low
	logic        ck, cs_n, dqs_i; // Link from the controller
	logic [9:0]  ca;              // Command/address
	logic [7:0]  dq_i, dq_o;      // Data both ways
	logic        dq_oe, dqs_o, dqs_oe, wr_valid, wr_overflow, cmd_err;
	logic [10:0] rd_addr, wr_col; // Column outputs
	logic [7:0]  wr_data, open_banks;
	logic [7:0]  rd_data = 8'h00; // User memory answer
	logic        wr_ready = 1'b1; // User side accepts writes
	int          failures = 0, samples_checked = 0;
	int          errs = 0, ovf = 0, pops = 0, pre = 0, pre_len = 0;
	logic [7:0]  rq[$];           // Read beats seen
	realtime     tq[$];           // Their times
	logic        dqs_d = 1'b0;    // Strobe one clock ago
	// 50 MHz clock
	always #10 clk = ~clk;
	ctl_model #(.WL(WL)) u_ctl (.ck(ck), .cs_n(cs_n), .ca(ca), .dq(dq_i), .dqs(dqs_i));
	ddr_die_core #(.RL(RL), .WL(WL), .BL(8), .DQ_W(8)) u_dut (.clk(clk), .nrst(nrst),
		.ck(ck), .cs_n(cs_n), .ca(ca), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
		.dqs_i(dqs_i), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .rd_addr(rd_addr),
		.rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_col(wr_col),
		.wr_data(wr_data), .wr_overflow(wr_overflow), .open_banks(open_banks),
		.cmd_err(cmd_err));
	// User memory: data is a fixed function of the column
	always @(posedge clk) begin
		#2 rd_data = rd_addr[7:0] ^ 8'h5a;
	end
	// Pin monitor: read beats, preamble length, error, loss and pop counts
	// Sampled mid-cycle so it never races the outputs' own update edge
	always @(negedge clk) begin
		if (dq_oe && dqs_o !== dqs_d) begin
			if (rq.size() == 0)
				pre_len = pre;
			rq.push_back(dq_o);
			tq.push_back($realtime);
		end
		pre = (dqs_oe && !dq_oe && !dqs_o) ? pre + 1 : 0;
		errs += int'(cmd_err);
		ovf += int'(wr_overflow);
		pops += int'(wr_valid && wr_ready);
		dqs_d = dqs_o;
	end
	// Value compare
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Window compare for times and lengths
	task automatic cmp_in(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	// Verdict and end of run
	task automatic test_done();
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// READ or WRITE: bank, column split over both halves
	task automatic col_cmd(input logic rd, input logic [2:0] b, input logic [10:0] c);
		u_ctl.cmd({b, c[1:0], 2'b00, rd, 2'b01}, {c[10:2], 1'b0});
	endtask
	// Wait whole link clocks
	task automatic gap(input int k);
		repeat (k) @(posedge ck);
	endtask
	// Wait for read beats, bounded
	task automatic chk_rd(input int n, input logic [10:0] c0, input logic [10:0] c1);
		int k;
		for (k = 0; k < 2000 && rq.size() < n; k++) @(posedge clk);
		if (k == 2000) begin
			failures++;
			test_done();
		end
		repeat (60) @(posedge clk); // Let any surplus beat show
		cmp(rq.size(), n);
		for (int i = 0; i < n; i++)
			cmp(rq[i], 8'(i < 8 ? c0 + i : c1 + i - 8) ^ 8'h5a);
	endtask
	// Take n write words from the user side, bounded
	task automatic take_wr(input int n, input logic [10:0] c, input logic [7:0] d);
		int k;
		for (int i = 0; i < n; i++) begin
			k = 0;
			do begin
				@(negedge clk);
				k++;
			end while (k < 800 && !(wr_valid === 1'b1 && wr_ready === 1'b1));
			if (k == 800) begin
				failures++;
				test_done();
			end
			cmp({wr_col, wr_data}, {11'(c + i), 8'(d + i)});
			@(posedge clk);
		end
	endtask
	// Bank open and misuse flags
	task automatic t_open();
		cmp({dq_oe, dqs_oe, wr_valid, open_banks}, 32'h0);
		u_ctl.cmd(10'h102, 10'h000);
		u_ctl.cmd(10'h182, 10'h000);
		gap(1);
		cmp(open_banks, 8'h0c);
		u_ctl.cmd(10'h102, 10'h000);
		gap(1);
		cmp(errs, 1);
		col_cmd(1'b0, 3'd5, 11'h000);
		// The write still runs, so it gets its data like any other write
		fork
			u_ctl.burst(8, 8'h70);
			take_wr(8, 11'h000, 8'h70);
		join
		gap(2);
		cmp(errs, 2);
		cmp(pops, 8);
	endtask
	// Single read: data, latency, preamble
	task automatic t_read();
		realtime t0;
		rq.delete();
		tq.delete();
		col_cmd(1'b1, 3'd2, 11'h123);
		t0 = u_ctl.t_cmd;
		chk_rd(8, 11'h123, 11'h000);
		cmp_in(int'(tq[0] - t0), RL * 160, RL * 160 + 140);
		cmp_in(pre_len, 7, 9);
	endtask
	// Two reads BL/2 apart, one unbroken stream
	task automatic t_read_gap();
		rq.delete();
		tq.delete();
		col_cmd(1'b1, 3'd3, 11'h040);
		gap(3);
		col_cmd(1'b1, 3'd3, 11'h200);
		chk_rd(16, 11'h040, 11'h200);
		cmp_in(int'(tq[15] - tq[0]), 15 * 80 - 20, 15 * 80 + 20);
	endtask
	// Read cut by terminate two clocks on
	task automatic t_read_bst();
		rq.delete();
		tq.delete();
		col_cmd(1'b1, 3'd2, 11'h300);
		u_ctl.cmd(10'h003, 10'h000);
		chk_rd(4, 11'h300, 11'h000);
	endtask
	// Write with the user side stalled at first
	task automatic t_write();
		gap(RL + 2);
		@(posedge clk) #2 wr_ready = 1'b0;
		col_cmd(1'b0, 3'd2, 11'h0a0);
		fork
			u_ctl.burst(8, 8'h30);
			begin
				repeat (34) @(posedge clk);
				#2 wr_ready = 1'b1;
				take_wr(8, 11'h0a0, 8'h30);
			end
		join
		cmp(ovf, 0);
	endtask
	// Write cut by a write two clocks on
	task automatic t_write_int();
		col_cmd(1'b0, 3'd2, 11'h100);
		fork
			u_ctl.burst(12, 8'h60);
			col_cmd(1'b0, 3'd3, 11'h180);
			begin
				take_wr(4, 11'h100, 8'h60);
				take_wr(8, 11'h180, 8'h64);
			end
		join
	endtask
	// Write cut by terminate: surplus beats ignored
	task automatic t_write_bst();
		int p0;
		gap(2);
		p0 = pops;
		col_cmd(1'b0, 3'd2, 11'h0c0);
		fork
			u_ctl.burst(8, 8'h50);
			u_ctl.cmd(10'h003, 10'h000);
			take_wr(4, 11'h0c0, 8'h50);
		join
		gap(2);
		cmp(pops - p0, 4);
	endtask
	// Two writes BL/2 apart
	task automatic t_write_gap();
		col_cmd(1'b0, 3'd3, 11'h010);
		fork
			u_ctl.burst(16, 8'h80);
			begin
				gap(3);
				col_cmd(1'b0, 3'd3, 11'h400);
			end
			begin
				take_wr(8, 11'h010, 8'h80);
				take_wr(8, 11'h400, 8'h88);
			end
		join
	endtask
	// Buffer filled until it refuses, then drained
	task automatic t_overflow();
		gap(2);
		@(posedge clk) #2 wr_ready = 1'b0;
		col_cmd(1'b0, 3'd2, 11'h050);
		u_ctl.burst(8, 8'h10);
		gap(2);
		cmp(ovf > 0, 1);
		@(posedge clk) #2 wr_ready = 1'b1;
		take_wr(1, 11'h050, 8'h10);
		gap(2);
	endtask
	// Precharge all closes every bank, then a bank reopens
	task automatic t_pre_all();
		int e0;
		e0 = errs;
		gap(2);
		// Single-bank precharge closes bank 3 only
		u_ctl.cmd(10'h18b, 10'h000);
		gap(1);
		cmp(open_banks, 8'h04);
		u_ctl.cmd(10'h01b, 10'h000);
		gap(1);
		cmp(open_banks, 8'h00);
		u_ctl.cmd(10'h082, 10'h000);
		gap(1);
		cmp(open_banks, 8'h02);
		cmp(errs - e0, 0);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		#2 nrst = 1'b1;
		repeat (4) @(posedge clk);
		t_open();
		t_read();
		t_read_gap();
		t_read_bst();
		t_write();
		t_write_int();
		t_write_bst();
		t_write_gap();
		t_overflow();
		t_pre_all();
		test_done();
	end
endmodule
